// ==== design/ast_async_tx.sv ====
// asynchronous serial transmitter with rate divider and APB register slave
// assumes: one core clock, APB master on the same clock, sleep as a level input
//
// What this block does
// - NRZ frame: start, 8/9 data, stop
// - data shifted LSB first after start
// - dedicated 8-bit divisor timer from core clock
// - x16 when high speed, else x64
// - rate and format shared with receiver
// - no parity hardware; ninth bit by software
// - everything halts while asleep
// - async mode when clocked-mode bit zero
// - shift reload at end of stop bit, or at once when idle
// - flags set one instruction cycle after transfer
// - buffer-empty flag cleared only by buffer write
// - interrupt only when enable bit set
// - shift-empty follows shift register, polled only
// - shift register not software visible
// - enabling transmit sets buffer-empty flag
// - frame needs data and a shift clock
// - data first then enable also works
// - empty shifter takes buffer write immediately
// - clearing enable aborts frame, releases pin
// - rate = clock/(16 or 64 * (divisor+1))
// - divisor write clears the timer
// - timer held reset when all enables clear
`default_nettype none
`include "ast_map.svh"

module ast_async_tx (
   // clock, reset, enable
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic clkEn,
   input wire logic sleepReq,
   // apb
   input wire ast_pkg::ast_apb_req_t apbReq,
   output var ast_pkg::ast_apb_rsp_t apbRsp,
   // transmit pin and interrupt request
   output var ast_pkg::ast_pin_t pinOut
);
   import ast_pkg::*;

   logic [7:0] intCtl_reg;
   logic [7:0] pEn_reg;
   logic [7:0] rcsc_reg;
   logic [7:0] txBuf_reg;
   logic [7:0] baud_reg;
   // transmit status/control fields, kept apart
   logic nineSel_reg;
   logic transmit_enable_reg;
   logic syncSel_reg;
   logic hiSpd_reg;
   logic d9_reg;
   logic bufFull_reg;
   logic txeFlag_reg;
   logic shEmpty_reg;
   logic [7:0] divCnt_reg;
   logic [5:0] ovsCnt_reg;
   logic [8:0] shift_reg;
   logic [3:0] bitCnt_reg;
   logic frameNine_reg;
   ast_state_t state_reg;
   logic loadDly_reg;
   logic emptyDly_reg;
   logic txEnPrev_reg;

   // sleep freezes the whole block alongside the clock enable
   logic run;
   assign run = clkEn && !sleepReq;

   logic access, wr, rd;
   logic [7:0] idx;
   logic idxOk;
   assign access = apbReq.psel && apbReq.penable;
   assign wr = access && apbReq.pwrite;
   assign rd = access && !apbReq.pwrite;
   assign idx = apbReq.paddr[9:2];
   assign idxOk = (apbReq.paddr[1:0] == 2'h0) && (apbReq.paddr[11:10] == 2'h0);
   logic wrBuf, wrTxsc, wrBaud;
   assign wrBuf = run && wr && idxOk && idx == `AST_IDX_TXBUF;
   assign wrTxsc = run && wr && idxOk && idx == `AST_IDX_TXSC;
   assign wrBaud = run && wr && idxOk && idx == `AST_IDX_BAUD;
   logic [7:0] wdata;
   assign wdata = apbReq.pwdata[7:0];

   // plain registers
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         intCtl_reg <= `AST_RST_INTCTL;
         pEn_reg <= `AST_RST_PEN;
         rcsc_reg <= `AST_RST_RCSC;
         baud_reg <= `AST_RST_BAUD;
         nineSel_reg <= 1'b0;
         transmit_enable_reg <= 1'b0;
         syncSel_reg <= 1'b0;
         hiSpd_reg <= 1'b0;
         d9_reg <= 1'b0;
      end else if (run && wr && idxOk) begin
         case (idx)
            `AST_IDX_INTCTL: intCtl_reg <= wdata;
            `AST_IDX_PEN: pEn_reg <= wdata;
            `AST_IDX_RCSC: rcsc_reg <= wdata & 8'hF0;
            `AST_IDX_BAUD: baud_reg <= wdata;
            `AST_IDX_TXSC: begin
               nineSel_reg <= wdata[`AST_TXSC_NINE];
               transmit_enable_reg <= wdata[`AST_TXSC_TRANSMIT_ENABLE];
               syncSel_reg <= wdata[`AST_TXSC_SYNC];
               hiSpd_reg <= wdata[`AST_TXSC_HISPD];
               d9_reg <= wdata[`AST_TXSC_D9];
            end
            default: ;
         endcase
      end
   end

   // transmitter runs only in async mode with the port enabled
   logic active;
   assign active = transmit_enable_reg && !syncSel_reg && rcsc_reg[`AST_RCSC_PORTEN];

   // divider held while every enable is clear
   // one rate setting, shared with the receive side
   logic brgRun;
   assign brgRun = transmit_enable_reg || rcsc_reg[`AST_RCSC_CONTINUOUS_RECEIVE_ENABLE] || rcsc_reg[`AST_RCSC_SINGLE_RECEIVE_ENABLE];

   // 8-bit divisor timer; tick each divisor+1 clocks
   logic divTick;
   assign divTick = brgRun && divCnt_reg == 8'h00;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         divCnt_reg <= 8'h00;
      end else if (run) begin
         if (!brgRun || wrBaud) begin
            divCnt_reg <= 8'h00;
         end else if (shLoad || divCnt_reg == 8'h00) begin
            // re-phase on a load so the start bit is a whole bit;
            // costs the receive side its phase, which it re-finds per frame
            divCnt_reg <= baud_reg;
         end else begin
            divCnt_reg <= divCnt_reg - 8'h01;
         end
      end
   end

   // oversample count 16 or 64 ticks per bit
   // bit period = (16 or 64) * (divisor+1) clocks
   logic [6:0] ovsTop;
   logic bitTick;
   assign ovsTop = hiSpd_reg ? `AST_OVS_HIGH : `AST_OVS_LOW;
   assign bitTick = divTick && ({1'b0, ovsCnt_reg} == ovsTop - 7'd1);
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ovsCnt_reg <= 6'h00;
      end else if (run) begin
         if (!brgRun || wrBaud) begin
            ovsCnt_reg <= 6'h00;
         end else if (bitTick || shLoad) begin
            // a load restarts the bit so the start bit is full length
            ovsCnt_reg <= 6'h00;
         end else if (divTick) begin
            ovsCnt_reg <= ovsCnt_reg + 6'h01;
         end
      end
   end

   // empty shifter loads at once; else after stop bit
   logic shLoad;
   assign shLoad = active && bufFull_reg &&
      (state_reg == AST_IDLE || (state_reg == AST_STOP && bitTick));

   // transmit buffer
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         txBuf_reg <= `AST_RST_TXBUF;
         bufFull_reg <= 1'b0;
      end else if (run) begin
         if (wrBuf) begin
            txBuf_reg <= wdata;
            bufFull_reg <= 1'b1;
         end else if (shLoad) begin
            bufFull_reg <= 1'b0;
         end
      end
   end

   // frame sequencer; waits on data and bit clock
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= AST_IDLE;
         shift_reg <= 9'h000;
         bitCnt_reg <= 4'h0;
         frameNine_reg <= 1'b0;
      end else if (run) begin
         if (!active) begin
            state_reg <= AST_IDLE;
            bitCnt_reg <= 4'h0;
         end else if (shLoad) begin
            shift_reg <= {d9_reg, txBuf_reg};
            frameNine_reg <= nineSel_reg;
            bitCnt_reg <= 4'h0;
            state_reg <= AST_START;
         end else if (bitTick) begin
            case (state_reg)
               AST_START: state_reg <= AST_DATA;
               AST_DATA: begin
                  shift_reg <= {1'b0, shift_reg[8:1]};
                  bitCnt_reg <= bitCnt_reg + 4'h1;
                  if (bitCnt_reg == (frameNine_reg ? 4'h8 : 4'h7)) begin
                     state_reg <= AST_STOP;
                  end
               end
               AST_STOP: state_reg <= AST_IDLE;
               default: state_reg <= AST_IDLE;
            endcase
         end
      end
   end

   // flags follow one instruction cycle late
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         loadDly_reg <= 1'b0;
         emptyDly_reg <= 1'b1;
         shEmpty_reg <= 1'b1;
         txEnPrev_reg <= 1'b0;
         txeFlag_reg <= 1'b0;
      end else if (run) begin
         loadDly_reg <= shLoad;
         emptyDly_reg <= (state_reg == AST_IDLE) && !shLoad;
         shEmpty_reg <= emptyDly_reg;
         txEnPrev_reg <= transmit_enable_reg;
         // enable rising or transfer sets; set wins
         if ((transmit_enable_reg && !txEnPrev_reg) || loadDly_reg) begin
            txeFlag_reg <= 1'b1;
         end else if (wrBuf) begin
            txeFlag_reg <= 1'b0;
         end
      end
   end

   // idle high, start low, stop high; pin released off
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pinOut <= '{txOut: 1'b1, txOe: 1'b0, irq: 1'b0};
      end else if (run) begin
         pinOut.txOe <= active;
         case (state_reg)
            AST_START: pinOut.txOut <= 1'b0;
            AST_DATA: pinOut.txOut <= shift_reg[0];
            default: pinOut.txOut <= 1'b1;
         endcase
         pinOut.irq <= txeFlag_reg && pEn_reg[`AST_PEN_TXE] &&
            intCtl_reg[`AST_INTCTL_PERIPHERAL_IRQ_ENABLE] && intCtl_reg[`AST_INTCTL_GIE];
      end
   end

   // shift register never appears on the read path
   logic [7:0] rdMux;
   always_comb begin
      rdMux = 8'h00;
      case (idx)
         `AST_IDX_INTCTL: rdMux = intCtl_reg;
         `AST_IDX_PFLAGS: rdMux = 8'h00 | ({7'h00, txeFlag_reg} << `AST_PFLAGS_TXE);
         `AST_IDX_RCSC: rdMux = rcsc_reg;
         `AST_IDX_TXBUF: rdMux = txBuf_reg;
         `AST_IDX_PEN: rdMux = pEn_reg;
         `AST_IDX_BAUD: rdMux = baud_reg;
         `AST_IDX_TXSC: rdMux = {1'b0, nineSel_reg, transmit_enable_reg, syncSel_reg, 1'b0,
            hiSpd_reg, shEmpty_reg, d9_reg};
         default: rdMux = 8'h00;
      endcase
   end

   // zero-wait slave; unmapped reads return zero, no error
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         apbRsp <= '{pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000};
      end else begin
         apbRsp.pslverr <= 1'b0;
         apbRsp.pready <= run && apbReq.psel && !apbReq.penable;
         if (run && apbReq.psel && !apbReq.penable && !apbReq.pwrite) begin
            apbRsp.prdata <= idxOk ? {24'h000000, rdMux} : 32'h0000_0000;
         end
      end
   end
endmodule
`default_nettype wire

// ==== design/ast_map.svh ====
// register offsets, field positions, reset values and timing constants
// assumes: included by the transmitter package users; APB byte addressing
`ifndef AST_MAP_SVH
`define AST_MAP_SVH

// printed offsets are register indices; byte address is four times the index
`define AST_IDX_INTCTL 8'h0B
`define AST_IDX_PFLAGS 8'h0C
`define AST_IDX_RCSC 8'h18
`define AST_IDX_TXBUF 8'h19
`define AST_IDX_PEN 8'h8C
`define AST_IDX_TXSC 8'h98
`define AST_IDX_BAUD 8'h99

`define AST_RST_INTCTL 8'h00
`define AST_RST_PFLAGS 8'h00
`define AST_RST_RCSC 8'h00
`define AST_RST_TXBUF 8'h00
`define AST_RST_PEN 8'h00
`define AST_RST_TXSC 8'h02
`define AST_RST_BAUD 8'h00

// transmit status/control bits
`define AST_TXSC_NINE 6
`define AST_TXSC_TRANSMIT_ENABLE 5
`define AST_TXSC_SYNC 4
`define AST_TXSC_HISPD 2
`define AST_TXSC_SHEMPTY 1
`define AST_TXSC_D9 0
// receive status/control bits shared with this block
`define AST_RCSC_PORTEN 7
`define AST_RCSC_SINGLE_RECEIVE_ENABLE 5
`define AST_RCSC_CONTINUOUS_RECEIVE_ENABLE 4
// flag / enable / global bits
`define AST_PFLAGS_TXE 4
`define AST_PEN_TXE 4
`define AST_INTCTL_GIE 7
`define AST_INTCTL_PERIPHERAL_IRQ_ENABLE 6

// oversampling ratios
`define AST_OVS_HIGH 7'd16
`define AST_OVS_LOW 7'd64
// one instruction cycle, in core clocks
`define AST_INSTR_CYCLES 2'd1

`endif

// ==== design/ast_pkg.sv ====
// types shared by the async serial transmitter
// assumes: nothing beyond SystemVerilog
`default_nettype none
package ast_pkg;
   typedef enum logic [1:0] {AST_IDLE, AST_START, AST_DATA, AST_STOP} ast_state_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } ast_apb_req_t;
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } ast_apb_rsp_t;
   typedef struct packed {
      logic txOut;
      logic txOe;
      logic irq;
   } ast_pin_t;
endpackage
`default_nettype wire

// ==== sim/ast_tx_monitor.sv ====
// port checker for the async transmitter
// assumes: bound into ast_async_tx, byte address four times the index
`default_nettype none
module ast_tx_monitor (
   // clock and controls
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic clkEn,
   input wire logic sleepReq,
   // bus and pin
   input wire ast_pkg::ast_apb_req_t apbReq,
   input wire ast_pkg::ast_apb_rsp_t apbRsp,
   input wire ast_pkg::ast_pin_t pinOut
);
   import ast_pkg::*;
   logic wr;
   logic [7:0] idx, txscReg, rcscReg, penReg, intReg;
   assign wr = apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.pwrite;
   assign idx = apbReq.paddr[9:2];
   // control bits as last written
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) {txscReg, rcscReg, penReg, intReg} <= '0;
      else if (wr) begin
         if (idx == 8'h98) txscReg <= apbReq.pwdata[7:0];
         if (idx == 8'h18) rcscReg <= apbReq.pwdata[7:0];
         if (idx == 8'h8C) penReg <= apbReq.pwdata[7:0];
         if (idx == 8'h0B) intReg <= apbReq.pwdata[7:0];
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   a_zero_wait: assert property (apbReq.psel && !apbReq.penable && clkEn && !sleepReq
      |=> apbRsp.pready) else $error("pready late");
   a_ready_pulse: assert property (apbRsp.pready |=> !apbRsp.pready)
      else $error("pready held");
   a_no_error: assert property (!apbRsp.pslverr) else $error("pslverr raised");
   a_sleep_hold: assert property (sleepReq || !clkEn |=> $stable(pinOut))
      else $error("pin moved while halted");
   a_reset_idle: assert property (!$past(rst_b) |->
      pinOut.txOut && !pinOut.txOe && !pinOut.irq) else $error("pin not idle");
   a_irq_gate: assert property ($rose(pinOut.irq) |->
      penReg[4] && intReg[7] && intReg[6]) else $error("irq while masked");
   a_oe_gate: assert property ($rose(pinOut.txOe) |->
      txscReg[5] && !txscReg[4] && rcscReg[7]) else $error("pin driven while off");
   a_oe_drop: assert property (wr && idx == 8'h98 && !apbReq.pwdata[5] |->
      ##[1:2] !pinOut.txOe) else $error("pin kept after disable");
endmodule
bind ast_async_tx ast_tx_monitor mon (.clk_sys(clk_sys), .rst_b(rst_b), .clkEn(clkEn),
   .sleepReq(sleepReq), .apbReq(apbReq), .apbRsp(apbRsp), .pinOut(pinOut));
`default_nettype wire

// ==== sim/ast_rx_model.sv ====
// far-end receiver on the transmit line
// assumes: line level resolved by the bench, bit time in core clocks
`default_nettype none
module ast_rx_model (
   // line
   input wire logic clk_sys,
   input wire logic txLine,
   input wire logic txDrive,
   // format
   input wire logic [15:0] bitClks,
   input wire logic nineBit,
   // received word
   output logic rxValid,
   output logic [8:0] rxWord,
   output logic rxBad
);
   logic lost;
   initial begin
      {rxValid, rxWord, rxBad} = '0;
      forever begin
         @(posedge clk_sys iff (txDrive && !txLine));
         lost = 1'b0;
         rxWord = '0;
         repeat (bitClks / 2) @(posedge clk_sys);
         rxBad = txLine;
         // lsb first, ninth bit as sent
         for (int i = 0; i < (nineBit ? 9 : 8); i++) begin
            repeat (bitClks) @(posedge clk_sys);
            rxWord[i] = txLine;
            lost = lost | !txDrive;
         end
         repeat (bitClks) @(posedge clk_sys);
         rxBad = rxBad | !txLine;
         // frames cut short by an abort are dropped
         if (!lost && txDrive) begin
            rxValid = 1'b1;
            @(posedge clk_sys);
            rxValid = 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ==== sim/tb_async_serial_transmitter.sv ====
// self-checking bench for the async serial transmitter
// assumes: design, monitor and receiver model compiled before it
`default_nettype none
module tb_async_serial_transmitter;
   timeunit 1ns;
   timeprecision 1ps;
   import ast_pkg::*;
   logic clk_sys, rst_b, clkEn, sleepReq, nineBit, rxValid, rxBad, txWire;
   logic [8:0] rxWord;
   ast_apb_req_t apbReq;
   ast_apb_rsp_t apbRsp;
   ast_pin_t pinOut;
   int error_cnt = 0, n_checks = 0, seed = 45652, bitClks = 32, cyc = 0;
   logic [8:0] frmQ[$];
   logic [31:0] rdQ[$];
   logic [7:0] ix[8] = '{8'h0B, 8'h0C, 8'h18, 8'h19, 8'h8C, 8'h98, 8'h99, 8'h1A};
   logic [7:0] rv[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
   // released line floats high on its pull-up
   assign txWire = pinOut.txOe ? pinOut.txOut : 1'b1;
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   ast_async_tx dut (.clk_sys(clk_sys), .rst_b(rst_b), .clkEn(clkEn), .sleepReq(sleepReq),
      .apbReq(apbReq), .apbRsp(apbRsp), .pinOut(pinOut));
   ast_rx_model far (.clk_sys(clk_sys), .txLine(txWire), .txDrive(pinOut.txOe),
      .bitClks(bitClks[15:0]), .nineBit(nineBit), .rxValid(rxValid), .rxWord(rxWord),
      .rxBad(rxBad));
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      if (!w) rdQ.push_back({24'h000000, d});
      apbReq <= '{1'b1, 1'b0, w, {2'b00, a, 2'b00}, {24'h000000, d}};
      tick(1);
      apbReq.penable <= 1'b1;
      do tick(1); while (apbRsp.pready !== 1'b1);
      apbReq <= '0;
      tick(1);
   endtask
   function automatic logic [8:0] rw(input logic b9);
      return {b9, 8'($random(seed))};
   endfunction
   task automatic send(input logic [8:0] w);
      frmQ.push_back(w);
      apb(1'b1, 8'h19, w[7:0]);
   endtask
   task automatic drain;
      while (frmQ.size() != 0) tick(1);
      tick(bitClks);
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   always @(posedge clk_sys)
      if (apbReq.psel && apbReq.penable && !apbReq.pwrite && apbRsp.pready === 1'b1)
         cmp(apbRsp.prdata, rdQ.pop_front());
   always @(posedge rxValid) cmp({rxBad, rxWord}, {1'b0, frmQ.pop_front()});
   initial begin
      {rst_b, sleepReq, nineBit} = '0;
      clkEn = 1'b1;
      apbReq = '0;
      tick(3);
      rst_b <= 1'b1;
      tick(1);
      foreach (ix[i]) apb(1'b0, ix[i], rv[i]);
      $display("reset values done");
      apb(1'b1, 8'h99, 8'h01);
      apb(1'b1, 8'h98, 8'h04);
      apb(1'b1, 8'h18, 8'h80);
      apb(1'b1, 8'h8C, 8'h10);
      apb(1'b1, 8'h0B, 8'hC0);
      apb(1'b1, 8'h98, 8'h24);
      apb(1'b0, 8'h0C, 8'h10);
      cmp(pinOut.irq, 1'b1);
      send(rw(1'b0));
      send(rw(1'b0));
      apb(1'b0, 8'h98, 8'h24);
      repeat (3) begin
         while (pinOut.irq !== 1'b1) tick(1);
         send(rw(1'b0));
         tick(2);
         cmp(pinOut.irq, 1'b0);
      end
      drain();
      apb(1'b0, 8'h98, 8'h26);
      apb(1'b1, 8'h8C, 8'h00);
      tick(2);
      cmp(pinOut.irq, 1'b0);
      $display("back to back done");
      nineBit <= 1'b1;
      for (int b = 0; b < 2; b++) begin
         apb(1'b1, 8'h98, {7'h32, b[0]});
         send(rw(b[0]));
         drain();
      end
      $display("nine bit done");
      nineBit <= 1'b0;
      bitClks = 64;
      apb(1'b1, 8'h98, 8'h20);
      apb(1'b1, 8'h99, 8'h00);
      send(rw(1'b0));
      drain();
      apb(1'b1, 8'h19, 8'h00);
      tick(200);
      apb(1'b1, 8'h98, 8'h00);
      tick(1);
      cmp(pinOut.txOe, 1'b0);
      tick(700);
      send(rw(1'b0));
      tick(20);
      cmp(pinOut.txOe, 1'b0);
      apb(1'b1, 8'h98, 8'h20);
      drain();
      $display("abort and restart done");
      sleepReq <= 1'b1;
      tick(20);
      sleepReq <= 1'b0;
      clkEn <= 1'b0;
      tick(5);
      clkEn <= 1'b1;
      apb(1'b0, 8'h99, 8'h00);
      $display("sleep done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
